// ---- dv/scan_controller.sv ----
// Behavioural board-level scan controller that steps the test port one clock at a time.
`default_nettype none

module scan_controller (
   // Test link toward the device
   output var logic tck,
   output var logic tms,
   output var logic tdi,
   // Answer from the device
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   // The test clock stands low between frames, as a real controller leaves it.
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // mode and data set after the fall, answer read just before the rise.
   task automatic tick(input logic m, input logic d, output logic q, output logic oe);
      #1;
      tms = m;
      tdi = d;
      #78;
      q = tdo;
      oe = tdo_oe;
      #1;
      tck = 1'b1;
      #80;
      tck = 1'b0;
   endtask

   // Outside a shift the data line toggles, so a stale level never reads as valid.
   task automatic step(input logic m);
      logic q;
      logic oe;
      tick(m, ~tdi, q, oe);
   endtask

   // mode select held high for the given count of rising edges, then idle.
   task automatic reset_tap(input int n);
      repeat (n) step(1'b1);
      step(1'b0);
   endtask

   // walk from idle through capture, shift and update of one path.
   task automatic scan(input logic ir, input int n, input logic [79:0] din,
                       output logic [79:0] dout, output logic oe_ok);
      logic q;
      logic oe;
      dout = '0;
      oe_ok = 1'b1;
      step(1'b1);
      if (ir) begin
         step(1'b1);
      end
      step(1'b0);
      step(1'b0);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q, oe);
         dout[i] = q;
         oe_ok &= oe;
      end
      tick(1'b1, ~tdi, q, oe);
      oe_ok &= ~oe;
      step(1'b0);
   endtask
endmodule // scan_controller

`default_nettype wire

// ---- dv/test_memory_test_access_port.sv ----
// Self-checking bench for the memory test access port.
`default_nettype none

module test_memory_test_access_port;
   timeunit 1ns;
   timeprecision 100ps;

   logic                        MCLK;
   logic                        ARST_N;
   logic                        TCK;
   logic                        TMS;
   logic                        TDI;
   logic                        TDO;
   logic                        TDO_OE;
   logic [tap_pkg::CHAIN_W-1:0] RING_IN;
   logic                        MEM_OUT_HIZ;
   logic [79:0]                 got;
   logic                        oe_ok;
   logic                        tdo_at_rise;
   int                          fail_count;
   int                          n_compared;
   // reserved codes are never loaded; the last listed code leaves outputs floated.
   logic [2:0]                  codes [3] = '{3'h4, 3'h0, 3'h2};

   memory_test_access_port uut (
      .MCLK        (MCLK),
      .ARST_N      (ARST_N),
      .TCK         (TCK),
      .TMS         (TMS),
      .TDI         (TDI),
      .TDO         (TDO),
      .TDO_OE      (TDO_OE),
      .RING_IN     (RING_IN),
      .MEM_OUT_HIZ (MEM_OUT_HIZ)
   );

   scan_controller ctl (
      .tck    (TCK),
      .tms    (TMS),
      .tdi    (TDI),
      .tdo    (TDO),
      .tdo_oe (TDO_OE)
   );

   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end

   task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] seen);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check_hiz(input logic exp);
      repeat (4) @(negedge MCLK);
      chk("memory outputs floated", {79'h0, exp}, {79'h0, MEM_OUT_HIZ});
   endtask

   task automatic check_id;
      ctl.scan(1'b0, 32, 80'h0, got, oe_ok);
      chk("identification word", {48'h0, tap_pkg::ID_WORD}, got);
      chk("identification present bit", 80'h1, {79'h0, got[0]});
      chk("serial out enable", 80'h1, {79'h0, oe_ok});
   endtask

   // serial out must hold across every rising edge.
   always @(posedge TCK) begin
      tdo_at_rise = TDO;
      #20;
      chk("serial out after rise", {79'h0, tdo_at_rise}, {79'h0, TDO});
   end

   // Tests need under a fifth of this span.
   initial begin
      #400000;
      fail_count++;
      $display("unexpected run length: expected completion, seen none");
      summarize();
   end

   initial begin
      fail_count = 0;
      n_compared = 0;
      ARST_N = 1'b0;
      RING_IN = '0;
      repeat (3) @(posedge MCLK);
      ARST_N <= 1'b1;
      #3;
      ctl.reset_tap(8);
      check_id();
      check_hiz(1'b0);
      $display("test identification after power-up done");
      foreach (codes[k]) begin
         @(posedge MCLK);
         RING_IN <= {5'h15, 64'hfedcba9876543210} ^ {66'h0, codes[k]};
         ctl.scan(1'b1, 3, {77'h0, codes[k]}, got, oe_ok);
         chk("instruction capture", {77'h0, tap_pkg::IR_CAPTURE}, got);
         check_hiz(codes[k] != 3'h4);
         ctl.scan(1'b0, 77, 80'hc3, got, oe_ok);
         chk("boundary chain", {3'h0, 8'hc3, RING_IN}, got);
         chk("chain out enable", 80'h1, {79'h0, oe_ok});
         $display("test boundary code %h done", codes[k]);
      end
      ctl.scan(1'b1, 3, 80'h7, got, oe_ok);
      check_hiz(1'b0);
      ctl.scan(1'b0, 9, 80'h0b5, got, oe_ok);
      chk("bypass path", {71'h0, 8'hb5, 1'b0}, got);
      $display("test bypass done");
      ctl.scan(1'b1, 3, 80'h0, got, oe_ok);
      check_hiz(1'b1);
      ctl.reset_tap(5);
      check_hiz(1'b0);
      check_id();
      $display("test mode-select reset done");
      ctl.scan(1'b1, 3, 80'h1, got, oe_ok);
      check_id();
      $display("test identification load done");
      summarize();
   end
endmodule // test_memory_test_access_port

`default_nettype wire

// ---- logic/memory_test_access_port.sv ----
// Test access port of the pipelined memory: instruction, bypass, identification and boundary chain.
`default_nettype none

module memory_test_access_port (
   // System clock and reset
   input  wire logic                         MCLK,
   input  wire logic                         ARST_N,
   // Test port pins
   input  wire logic                         TCK,
   input  wire logic                         TMS,
   input  wire logic                         TDI,
   output logic                              TDO,
   output logic                              TDO_OE,
   // Memory I/O ring
   input  wire logic [tap_pkg::CHAIN_W-1:0]  RING_IN,
   output logic                              MEM_OUT_HIZ
);

   logic                        tck_rst_meta_r;
   logic                        tck_rst_n_r;
   logic [tap_pkg::CHAIN_W-1:0] ring_meta_r;
   logic [tap_pkg::CHAIN_W-1:0] ring_sync_r;
   logic [tap_pkg::IR_W-1:0]    ir_shift_r;
   logic [tap_pkg::IR_W-1:0]    ir_r;
   logic                        bypass_r;
   logic [tap_pkg::ID_W-1:0]    id_shift_r;
   logic [tap_pkg::CHAIN_W-1:0] bsr_r;
   logic                        hiz_tck_r;
   logic                        hiz_meta_r;
   logic                        hiz_sync_r;
   logic                        tdo_nxt;
   logic                        tdo_r;
   logic                        tdo_oe_r;

   tap_ctrl_if ctl ();

   // chain selection
   // The boundary chain is in the path for the three capture instructions.
   function automatic logic chain_selected(input logic [tap_pkg::IR_W-1:0] code);
      return (code == tap_pkg::IR_EXTEST) || (code == tap_pkg::IR_SAMPLE_Z) || (code == tap_pkg::IR_SAMPLE);
   endfunction

   // code 100 keeps drivers
   // Memory outputs float under the two high-impedance capture instructions.
   function automatic logic hiz_selected(input logic [tap_pkg::IR_W-1:0] code);
      return (code == tap_pkg::IR_EXTEST) || (code == tap_pkg::IR_SAMPLE_Z);
   endfunction

   // The test clock domain leaves reset only after two test clock edges, so the
   // controller never sees a release that lands close to a test clock edge.
   always_ff @(posedge TCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tck_rst_meta_r <= 1'b0;
         tck_rst_n_r    <= 1'b0;
      end else begin
         tck_rst_meta_r <= 1'b1;
         tck_rst_n_r    <= tck_rst_meta_r;
      end
   end

   tap_fsm u_fsm (
      .tck   (TCK),
      .rst_n (tck_rst_n_r),
      .tms   (TMS),
      .ctl   (ctl)
   );

   // The ring moves on the memory clock, so a bit caught mid-transition may read either way.
   always_ff @(posedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         ring_meta_r <= '0;
         ring_sync_r <= '0;
      end else begin
         ring_meta_r <= RING_IN;
         ring_sync_r <= ring_meta_r;
      end
   end

   always_ff @(posedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         ir_shift_r <= tap_pkg::IR_CAPTURE;
      end else if (ctl.capture_ir) begin
         ir_shift_r <= tap_pkg::IR_CAPTURE;
      end else if (ctl.shift_ir) begin
         ir_shift_r <= {TDI, ir_shift_r[tap_pkg::IR_W-1:1]};
      end
   end

   always_ff @(posedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         ir_r <= tap_pkg::IR_IDCODE;
      end else if (ctl.tlr) begin
         ir_r <= tap_pkg::IR_IDCODE;
      end else if (ctl.update_ir) begin
         ir_r <= ir_shift_r;
      end
   end

   always_ff @(posedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         bypass_r <= 1'b0;
      end else if (ctl.capture_dr) begin
         bypass_r <= 1'b0;
      end else if (ctl.shift_dr) begin
         bypass_r <= TDI;
      end
   end

   always_ff @(posedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         id_shift_r <= tap_pkg::ID_WORD;
      end else if (ctl.capture_dr && (ir_r == tap_pkg::IR_IDCODE)) begin
         id_shift_r <= tap_pkg::ID_WORD;
      end else if (ctl.shift_dr && (ir_r == tap_pkg::IR_IDCODE)) begin
         id_shift_r <= {TDI, id_shift_r[tap_pkg::ID_W-1:1]};
      end
   end

   // 69-bit boundary chain
   // There is no preload stage: shifted-in data is discarded, as update drives nothing.
   always_ff @(posedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         bsr_r <= '0;
      end else if (ctl.capture_dr && chain_selected(ir_r)) begin
         bsr_r <= ring_sync_r;
      end else if (ctl.shift_dr && chain_selected(ir_r)) begin
         bsr_r <= {TDI, bsr_r[tap_pkg::CHAIN_W-1:1]};
      end
   end

   // high-Z follows instruction
   // Set together with the instruction, so the outputs float even if the test clock stops after update.
   always_ff @(posedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         hiz_tck_r <= 1'b0;
      end else if (ctl.tlr) begin
         hiz_tck_r <= hiz_selected(tap_pkg::IR_IDCODE);
      end else if (ctl.update_ir) begin
         hiz_tck_r <= hiz_selected(ir_shift_r);
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         hiz_meta_r <= 1'b0;
         hiz_sync_r <= 1'b0;
      end else begin
         hiz_meta_r <= hiz_tck_r;
         hiz_sync_r <= hiz_meta_r;
      end
   end

   assign MEM_OUT_HIZ = hiz_sync_r;

   // Reserved codes fall back to the bypass bit so the scan path length stays defined.
   always_comb begin
      tdo_nxt = bypass_r;
      if (ctl.shift_ir) begin
         tdo_nxt = ir_shift_r[0];
      end else if (ir_r == tap_pkg::IR_IDCODE) begin
         tdo_nxt = id_shift_r[0];
      end else if (chain_selected(ir_r)) begin
         tdo_nxt = bsr_r[0];
      end
   end

   always_ff @(negedge TCK or negedge tck_rst_n_r) begin
      if (!tck_rst_n_r) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else begin
         tdo_r    <= tdo_nxt;
         tdo_oe_r <= ctl.shift_ir || ctl.shift_dr;
      end
   end

   assign TDO    = tdo_r;
   assign TDO_OE = tdo_oe_r;

   property p_ir_reset;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.tlr |=> (ir_r == tap_pkg::IR_IDCODE);
   endproperty
   a_ir_reset: assert property (p_ir_reset) else $error("Reset state did not load identification code.");

   property p_ir_capture;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.capture_ir |=> (ir_shift_r[1:0] == 2'b01);
   endproperty
   a_ir_capture: assert property (p_ir_capture) else $error("Instruction capture pattern wrong.");

   property p_hiz_extest;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      (ir_r == tap_pkg::IR_EXTEST) && $stable(ir_r) |-> hiz_tck_r;
   endproperty
   a_hiz_extest: assert property (p_hiz_extest) else $error("Outputs not floated under code 000.");

   property p_hiz_samplez;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      (ir_r == tap_pkg::IR_SAMPLE_Z) ##1 (ir_r == tap_pkg::IR_SAMPLE_Z) |-> hiz_tck_r;
   endproperty
   a_hiz_samplez: assert property (p_hiz_samplez) else $error("Outputs not floated under code 010.");

   property p_sample_drives;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      (ir_r == tap_pkg::IR_SAMPLE) |-> !hiz_tck_r;
   endproperty
   a_sample_drives: assert property (p_sample_drives) else $error("Code 100 floated the outputs.");

   property p_id_capture;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.capture_dr && (ir_r == tap_pkg::IR_IDCODE) |=>
         (id_shift_r[0] == 1'b1) && (id_shift_r[11:1] == tap_pkg::ID_VENDOR)
         && (id_shift_r[31:29] == tap_pkg::ID_REVISION) && (id_shift_r[28:12] == tap_pkg::ID_DEVICE);
   endproperty
   a_id_capture: assert property (p_id_capture) else $error("Identification word captured wrong.");

   property p_bypass_shift;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.shift_dr && (ir_r == tap_pkg::IR_BYPASS) |=> (bypass_r == $past(TDI));
   endproperty
   a_bypass_shift: assert property (p_bypass_shift) else $error("Bypass bit did not take serial input.");

   property p_chain_shift;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.shift_dr && chain_selected(ir_r) |=>
         (bsr_r[tap_pkg::CHAIN_W-1] == $past(TDI)) && (bsr_r[67:0] == $past(bsr_r[68:1]));
   endproperty
   a_chain_shift: assert property (p_chain_shift) else $error("Boundary chain shift wrong.");

   property p_five_high;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      TMS [*5] |=> ctl.tlr;
   endproperty
   a_five_high: assert property (p_five_high) else $error("Five high mode selects did not reset the port.");

   property p_rti_step;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      (ctl.state == tap_pkg::ST_RTI) && TMS |=> (ctl.state == tap_pkg::ST_SEL_DR);
   endproperty
   a_rti_step: assert property (p_rti_step) else $error("Idle state did not step on mode select.");

   property p_tdo_fall;
      @(negedge TCK) disable iff (!tck_rst_n_r)
      ctl.shift_dr && (ir_r == tap_pkg::IR_BYPASS) |=> (tdo_r == $past(bypass_r)) && tdo_oe_r;
   endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("Serial output not updated at falling edge.");

   property p_tdo_quiet;
      @(negedge TCK) disable iff (!tck_rst_n_r)
      !(ctl.shift_ir || ctl.shift_dr) |=> !tdo_oe_r;
   endproperty
   a_tdo_quiet: assert property (p_tdo_quiet) else $error("Serial out enabled outside a shift.");

   property p_ir_update;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.update_ir |=> (ir_r == $past(ir_shift_r));
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("Instruction update did not take shifted code.");

   property p_ir_shift;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.shift_ir |=> (ir_shift_r == {$past(TDI), $past(ir_shift_r[2:1])});
   endproperty
   a_ir_shift: assert property (p_ir_shift) else $error("Instruction shift wrong.");

   property p_tlr_hold;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.tlr && TMS |=> ctl.tlr;
   endproperty
   a_tlr_hold: assert property (p_tlr_hold) else $error("Reset state left with mode select high.");

   property p_bypass_capture;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.capture_dr |=> !bypass_r;
   endproperty
   a_bypass_capture: assert property (p_bypass_capture) else $error("Bypass bit not cleared at capture.");

   property p_id_shift;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.shift_dr && (ir_r == tap_pkg::IR_IDCODE) |=>
         (id_shift_r[31] == $past(TDI)) && (id_shift_r[30:0] == $past(id_shift_r[31:1]));
   endproperty
   a_id_shift: assert property (p_id_shift) else $error("Identification word shift wrong.");

   property p_chain_capture;
      @(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.capture_dr && chain_selected(ir_r) |=> (bsr_r == $past(ring_sync_r));
   endproperty
   a_chain_capture: assert property (p_chain_capture) else $error("Boundary chain capture wrong.");

   c_id_shift: cover property (@(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.shift_dr && (ir_r == tap_pkg::IR_IDCODE));
   c_bypass_shift: cover property (@(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.shift_dr && (ir_r == tap_pkg::IR_BYPASS));
   c_extest_hiz: cover property (@(posedge TCK) disable iff (!tck_rst_n_r)
      (ir_r == tap_pkg::IR_EXTEST) ##1 hiz_tck_r);
   c_ir_update: cover property (@(posedge TCK) disable iff (!tck_rst_n_r)
      ctl.update_ir ##1 (ir_r == tap_pkg::IR_SAMPLE));

endmodule // memory_test_access_port

`default_nettype wire

// ---- logic/tap_ctrl_if.sv ----
// State and phase strobes passed from the controller to the scan registers.
`default_nettype none

interface tap_ctrl_if;
   tap_pkg::tap_state_t state;
   logic                tlr;
   logic                capture_ir;
   logic                shift_ir;
   logic                update_ir;
   logic                capture_dr;
   logic                shift_dr;

   modport fsm  (output state, tlr, capture_ir, shift_ir, update_ir, capture_dr, shift_dr);
   modport core (input  state, tlr, capture_ir, shift_ir, update_ir, capture_dr, shift_dr);
endinterface

`default_nettype wire

// ---- logic/tap_fsm.sv ----
// Sixteen-state test port controller stepped by mode select on the test clock.
`default_nettype none

module tap_fsm (
   // Clock and reset
   input  wire logic tck,
   input  wire logic rst_n,
   // Mode select
   input  wire logic tms,
   // Phase strobes
   tap_ctrl_if.fsm   ctl
);

   tap_pkg::tap_state_t state_r;
   tap_pkg::tap_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         tap_pkg::ST_TLR:      state_nxt = tms ? tap_pkg::ST_TLR      : tap_pkg::ST_RTI;
         tap_pkg::ST_RTI:      state_nxt = tms ? tap_pkg::ST_SEL_DR   : tap_pkg::ST_RTI;
         tap_pkg::ST_SEL_DR:   state_nxt = tms ? tap_pkg::ST_SEL_IR   : tap_pkg::ST_CAP_DR;
         tap_pkg::ST_CAP_DR:   state_nxt = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_SHIFT_DR: state_nxt = tms ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_EXIT1_DR: state_nxt = tms ? tap_pkg::ST_UPD_DR   : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_PAUSE_DR: state_nxt = tms ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
         tap_pkg::ST_EXIT2_DR: state_nxt = tms ? tap_pkg::ST_UPD_DR   : tap_pkg::ST_SHIFT_DR;
         tap_pkg::ST_UPD_DR:   state_nxt = tms ? tap_pkg::ST_SEL_DR   : tap_pkg::ST_RTI;
         tap_pkg::ST_SEL_IR:   state_nxt = tms ? tap_pkg::ST_TLR      : tap_pkg::ST_CAP_IR;
         tap_pkg::ST_CAP_IR:   state_nxt = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_SHIFT_IR: state_nxt = tms ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_EXIT1_IR: state_nxt = tms ? tap_pkg::ST_UPD_IR   : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_PAUSE_IR: state_nxt = tms ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
         tap_pkg::ST_EXIT2_IR: state_nxt = tms ? tap_pkg::ST_UPD_IR   : tap_pkg::ST_SHIFT_IR;
         tap_pkg::ST_UPD_IR:   state_nxt = tms ? tap_pkg::ST_SEL_DR   : tap_pkg::ST_RTI;
         default:              state_nxt = tap_pkg::ST_TLR;
      endcase
   end

   always_ff @(posedge tck or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= tap_pkg::ST_TLR;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign ctl.state      = state_r;
   assign ctl.tlr        = (state_r == tap_pkg::ST_TLR);
   assign ctl.capture_ir = (state_r == tap_pkg::ST_CAP_IR);
   assign ctl.shift_ir   = (state_r == tap_pkg::ST_SHIFT_IR);
   assign ctl.update_ir  = (state_r == tap_pkg::ST_UPD_IR);
   assign ctl.capture_dr = (state_r == tap_pkg::ST_CAP_DR);
   assign ctl.shift_dr   = (state_r == tap_pkg::ST_SHIFT_DR);

endmodule // tap_fsm

`default_nettype wire

// ---- logic/tap_pkg.sv ----
// Constants, state type and field layout for the memory test access port.
// Contract
// - Code 000 captures ring, chain, outputs high-Z.
// - Code 001 selects the identification word.
// - Code 010 captures ring, chain, outputs high-Z.
// - Code 100 captures ring, chain, outputs untouched.
// - Code 111 selects the single bypass bit.
// - Boundary chain is 69 bits long.
// - Identification bit 0 always reads one.
// - Identification bits 11..1 hold vendor code.
// - Bits 31..29 revision, bits 28..12 device code.
// - State advances on mode select at rising edge.
// - Serial out changes on falling edge only.
// - Reset state loads identification instruction.
// - Instruction capture loads 01 into low bits.
`default_nettype none

package tap_pkg;

   localparam int IR_W    = 3;
   localparam int ID_W    = 32;
   localparam int CHAIN_W = 69;

   localparam logic [IR_W-1:0] IR_EXTEST   = 3'h0;
   localparam logic [IR_W-1:0] IR_IDCODE   = 3'h1;
   localparam logic [IR_W-1:0] IR_SAMPLE_Z = 3'h2;
   localparam logic [IR_W-1:0] IR_SAMPLE   = 3'h4;
   localparam logic [IR_W-1:0] IR_BYPASS   = 3'h7;
   localparam logic [IR_W-1:0] IR_CAPTURE  = 3'h1;

   // identification field layout
   // Identification fields; the revision, device and vendor values are arbitrary.
   localparam logic [2:0]  ID_REVISION = 3'h0;
   localparam logic [16:0] ID_DEVICE   = 17'h01234;
   localparam logic [10:0] ID_VENDOR   = 11'h0a5;
   localparam logic        ID_PRESENT  = 1'h1;
   localparam logic [ID_W-1:0] ID_WORD = {ID_REVISION, ID_DEVICE, ID_VENDOR, ID_PRESENT};

   typedef enum logic [3:0] {
      ST_TLR,
      ST_RTI,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPD_IR
   } tap_state_t;

endpackage

`default_nettype wire
